// >>> core/pm_regs_defines.svh
`ifndef PM_REGS_DEFINES_SVH
`define PM_REGS_DEFINES_SVH

// Configuration offsets (configuration-space byte address of each field)
`define POWER_CTRL_STATUS_OFF      8'h54
`define BRIDGE_POWER_EXT_OFF       8'h56
`define POWER_DATA_BYTE_OFF        8'h57
`define MSI_CAP_ID_OFF             8'h60

// Control/status field positions
`define WAKE_EVENT_STATUS_BIT      15
`define DATA_SCALE_MSB             14
`define DATA_SCALE_LSB             13
`define DATA_SELECT_MSB            12
`define DATA_SELECT_LSB            9
`define WAKE_ENABLE_BIT            8
`define CONTEXT_KEPT_BIT           3
`define POWER_LEVEL_MSB            1
`define POWER_LEVEL_LSB            0
`define CTRL_STATUS_WRITE_MASK     16'h0103

// Bridge extension field positions
`define CLOCK_STOP_FLAG_BIT        7
`define BUS_LEVEL_FLAG_BIT         6

// Reset and fixed values
`define POWER_CTRL_STATUS_RST      16'h0008
`define BRIDGE_POWER_EXT_RST       8'h40
`define POWER_DATA_BYTE_VAL        8'h00
`define MSI_CAP_ID_VAL             8'h05
`define POWER_LEVEL_RST            2'h0
`define WAKE_ENABLE_RST            1'h0

`endif

// >>> core/pm_regs_pkg.sv
package pm_regs_pkg;

  typedef enum logic [1:0] {
    LEVEL_ACTIVE     = 2'b00,
    LEVEL_LIGHT      = 2'b01,
    LEVEL_DEEP       = 2'b10,
    LEVEL_HOT_OFF    = 2'b11
  } power_level_t;

  typedef struct packed {
    power_level_t level;
    logic         wake_enable_scratch;
    logic [31:0]  rdata;
    logic         ack;
    logic         hit;
  } regs_state_t;

  typedef struct packed {
    logic         clock_stop;
    logic         resumed;
    logic         entered_hot_off;
    power_level_t prev_level;
  } clk_state_t;

endpackage

// >>> core/cfg_write_merge.sv
`timescale 1ns/1ns
`include "pm_regs_defines.svh"

module cfg_write_merge #(
  parameter int WIDTH = 16
) (
  input  wire logic [WIDTH-1:0]   old_i,
  input  wire logic [WIDTH-1:0]   wdata_i,
  input  wire logic [WIDTH/8-1:0] byte_en_i,
  input  wire logic [WIDTH-1:0]   write_mask_i,
  output logic      [WIDTH-1:0]   merged_o
);

  //////////////////////////////////////////////////////////////////////////////
  // Per-bit merge: only enabled lanes and writable bits take new data
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      always_comb begin
        if (byte_en_i[g/8] && write_mask_i[g]) begin
          merged_o[g] = wdata_i[g];
        end else begin
          merged_o[g] = old_i[g];
        end
      end
    end
  endgenerate

endmodule // cfg_write_merge

// >>> core/secondary_clock_ctrl.sv
`timescale 1ns/1ns
`include "pm_regs_defines.svh"

module secondary_clock_ctrl (
  input  wire logic                      sys_clk_i,
  input  wire logic                      reset_n_i,
  input  wire pm_regs_pkg::power_level_t level_i,
  input  wire logic                      stop_setting_i,
  output logic                           clock_stop_o,
  output logic                           resumed_o,
  output logic                           entered_hot_off_o
);

  pm_regs_pkg::clk_state_t st_ff;
  pm_regs_pkg::clk_state_t nxt_st;

  //////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    nxt_st            = st_ff;
    nxt_st.prev_level = level_i;
    nxt_st.clock_stop = stop_setting_i &&
                        (level_i == pm_regs_pkg::LEVEL_HOT_OFF);
    nxt_st.entered_hot_off = (level_i == pm_regs_pkg::LEVEL_HOT_OFF) &&
                             (st_ff.prev_level != pm_regs_pkg::LEVEL_HOT_OFF);
    // Wake-up is only reported, never turned into a reset
    nxt_st.resumed = (level_i == pm_regs_pkg::LEVEL_ACTIVE) &&
                     (st_ff.prev_level == pm_regs_pkg::LEVEL_HOT_OFF);
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_ff <= '{clock_stop: 1'b0, resumed: 1'b0, entered_hot_off: 1'b0,
                 prev_level: pm_regs_pkg::LEVEL_ACTIVE};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign clock_stop_o      = st_ff.clock_stop;
  assign resumed_o         = st_ff.resumed;
  assign entered_hot_off_o = st_ff.entered_hot_off;

endmodule // secondary_clock_ctrl

// >>> core/pci_power_mgmt_regs.sv
// Operation
// - Leaving hot off for active causes no internal reset and keeps all contents.
// - The wake event status bit 15 always reads zero and ignores writes.
// - The power reading multiplier bits 14:13 always read zero.
// - The power reading selector bits 12:9 always read zero.
// - Bit 8 is a scratch bit that resets to zero, returns the last write and does nothing else.
// - Bit 3 reads back the revision select input, zero when clear and one when set.
// - Bits 1:0 hold the power level, reset to active, and a write moves to the written level.
// - Reserved bits 7:4 and 2 of the control/status register always read zero.
// - Bit 7 of the bridge extension byte mirrors the secondary clock stop setting.
// - With that flag set the secondary clocks stop in the hot off state, otherwise they run.
// - Bit 6 of the bridge extension byte always reads one.
// - Bits 5:0 of the bridge extension byte always read zero.
// - The power data byte at 57h is read-only and always reads zero.
// - The byte at 60h is read-only and always reads the identifier 05h.
`timescale 1ns/1ns
`include "pm_regs_defines.svh"

module pci_power_mgmt_regs (
  input  wire logic        sys_clk_i,
  input  wire logic        reset_n_i,
  // Configuration access port
  input  wire logic        cfg_rd_i,
  input  wire logic        cfg_wr_i,
  input  wire logic [7:0]  cfg_addr_i,
  input  wire logic [3:0]  cfg_byte_en_i,
  input  wire logic [31:0] cfg_wdata_i,
  output logic      [31:0] cfg_rdata_o,
  output logic             cfg_ack_o,
  output logic             cfg_hit_o,
  // General control register bits
  input  wire logic        pm_revision_select_i,
  input  wire logic        secondary_clock_stop_setting_i,
  // Power management outputs
  output logic      [1:0]  device_power_level_o,
  output logic             secondary_clock_stop_o,
  output logic             resumed_from_hot_off_o,
  output logic             entered_hot_off_o
);

  //////////////////////////////////////////////////////////////////////////////
  // Decoding helpers

  // Dword that holds the control/status, extension and data bytes
  function automatic logic is_pm_dword(input logic [7:0] addr);
    logic [7:0] base;
    base = `POWER_CTRL_STATUS_OFF;
    is_pm_dword = (addr[7:2] == base[7:2]);
  endfunction

  // Dword that holds the capability identifier byte
  function automatic logic is_msi_dword(input logic [7:0] addr);
    logic [7:0] base;
    base = `MSI_CAP_ID_OFF;
    is_msi_dword = (addr[7:2] == base[7:2]);
  endfunction

  // Lane of a byte offset inside its dword
  function automatic logic [1:0] lane_of(input logic [7:0] offset);
    lane_of = offset[1:0];
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Read value builders

  function automatic logic [15:0] ctrl_status_value(
    input pm_regs_pkg::power_level_t level,
    input logic                      wake_en,
    input logic                      rev_sel
  );
    logic [15:0] v;
    v = 16'h0000;
    v[`WAKE_EVENT_STATUS_BIT] = 1'b0;
    v[`DATA_SCALE_MSB:`DATA_SCALE_LSB] = 2'h0;
    v[`DATA_SELECT_MSB:`DATA_SELECT_LSB] = 4'h0;
    v[`WAKE_ENABLE_BIT] = wake_en;
    v[7:4] = 4'h0;
    v[`CONTEXT_KEPT_BIT] = rev_sel;
    v[2] = 1'b0;
    v[`POWER_LEVEL_MSB:`POWER_LEVEL_LSB] = level;
    ctrl_status_value = v;
  endfunction

  function automatic logic [7:0] bridge_ext_value(input logic stop_setting);
    logic [7:0] v;
    v = 8'h00;
    v[`CLOCK_STOP_FLAG_BIT] = stop_setting;
    v[`BUS_LEVEL_FLAG_BIT] = 1'b1;
    bridge_ext_value = v;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // State

  pm_regs_pkg::regs_state_t st_ff;
  pm_regs_pkg::regs_state_t nxt_st;

  logic [15:0] ctrl_status_now;
  logic [15:0] ctrl_status_merged;
  logic [7:0]  bridge_ext_now;
  logic [31:0] pm_dword;
  logic [31:0] msi_dword;
  logic        access;
  logic        pm_hit;
  logic        msi_hit;
  logic        clock_stop;
  logic        resumed;
  logic        entered_hot_off;

  assign access = cfg_rd_i || cfg_wr_i;
  assign pm_hit = is_pm_dword(cfg_addr_i);
  assign msi_hit = is_msi_dword(cfg_addr_i);

  assign ctrl_status_now = ctrl_status_value(st_ff.level,
                                             st_ff.wake_enable_scratch,
                                             pm_revision_select_i);
  assign bridge_ext_now = bridge_ext_value(secondary_clock_stop_setting_i);

  //////////////////////////////////////////////////////////////////////////////
  // Read dword assembly

  always_comb begin
    pm_dword = 32'h0000_0000;
    pm_dword[15:0] = ctrl_status_now;
    pm_dword[lane_of(`BRIDGE_POWER_EXT_OFF)*8 +: 8] = bridge_ext_now;
    pm_dword[lane_of(`POWER_DATA_BYTE_OFF)*8 +: 8] = `POWER_DATA_BYTE_VAL;
  end

  always_comb begin
    msi_dword = 32'h0000_0000;
    msi_dword[lane_of(`MSI_CAP_ID_OFF)*8 +: 8] = `MSI_CAP_ID_VAL;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Write merge of the control/status word

  cfg_write_merge #(
    .WIDTH        (16)
  ) u_write_merge (
    .old_i        (ctrl_status_now),
    .wdata_i      (cfg_wdata_i[15:0]),
    .byte_en_i    (cfg_byte_en_i[1:0]),
    .write_mask_i (`CTRL_STATUS_WRITE_MASK),
    .merged_o     (ctrl_status_merged)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    nxt_st = st_ff;
    nxt_st.ack = access;
    nxt_st.hit = access && (pm_hit || msi_hit);
    if (cfg_rd_i) begin
      if (pm_hit) begin
        nxt_st.rdata = pm_dword;
      end else if (msi_hit) begin
        nxt_st.rdata = msi_dword;
      end else begin
        nxt_st.rdata = 32'h0000_0000;
      end
    end
    // Bytes at 56h, 57h and 60h are read-only: nothing to store
    if (cfg_wr_i && pm_hit) begin
      nxt_st.wake_enable_scratch = ctrl_status_merged[`WAKE_ENABLE_BIT];
      nxt_st.level = pm_regs_pkg::power_level_t'(
        ctrl_status_merged[`POWER_LEVEL_MSB:`POWER_LEVEL_LSB]);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register; only the device reset clears it, never a level change

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_ff <= '{level: pm_regs_pkg::LEVEL_ACTIVE,
                 wake_enable_scratch: `WAKE_ENABLE_RST,
                 rdata: 32'h0000_0000,
                 ack: 1'b0,
                 hit: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Secondary clock control

  secondary_clock_ctrl u_clock_ctrl (
    .sys_clk_i         (sys_clk_i),
    .reset_n_i         (reset_n_i),
    .level_i           (st_ff.level),
    .stop_setting_i    (secondary_clock_stop_setting_i),
    .clock_stop_o      (clock_stop),
    .resumed_o         (resumed),
    .entered_hot_off_o (entered_hot_off)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign cfg_rdata_o            = st_ff.rdata;
  assign cfg_ack_o              = st_ff.ack;
  assign cfg_hit_o              = st_ff.hit;
  assign device_power_level_o   = st_ff.level;
  assign secondary_clock_stop_o = clock_stop;
  assign resumed_from_hot_off_o = resumed;
  assign entered_hot_off_o      = entered_hot_off;

endmodule // pci_power_mgmt_regs

// >>> dv/pm_regs_checker_sva.sv
`timescale 1ns/1ns
module pm_regs_checker (
  input  wire logic        sys_clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        cfg_rd_i,
  input  wire logic        cfg_wr_i,
  input  wire logic [7:0]  cfg_addr_i,
  input  wire logic [3:0]  cfg_byte_en_i,
  input  wire logic [31:0] cfg_wdata_i,
  input  wire logic [31:0] cfg_rdata_o,
  input  wire logic        cfg_ack_o,
  input  wire logic        cfg_hit_o,
  input  wire logic        pm_revision_select_i,
  input  wire logic        secondary_clock_stop_setting_i,
  input  wire logic [1:0]  device_power_level_o,
  input  wire logic        secondary_clock_stop_o,
  input  wire logic        resumed_from_hot_off_o,
  input  wire logic        entered_hot_off_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  logic rd54;
  logic wr54;
  assign rd54 = cfg_rd_i && cfg_addr_i[7:2] == 6'h15;
  assign wr54 = cfg_wr_i && cfg_addr_i[7:2] == 6'h15;
  ////////////////////////////////////////////////////////////////////////////////
  ack_hit_a: assert property ((cfg_rd_i || cfg_wr_i) |=> cfg_ack_o && cfg_hit_o ==
    ($past(cfg_addr_i[7:2]) == 6'h15 || $past(cfg_addr_i[7:2]) == 6'h18))
    else $error("ack or hit wrong after request");
  fixed_ctrl_a: assert property (rd54 |=> cfg_rdata_o[15:9] == 7'h00
    && cfg_rdata_o[7:4] == 4'h0 && !cfg_rdata_o[2]) else $error("fixed status bits wrong");
  fixed_ext_a: assert property (rd54 |=> cfg_rdata_o[31:24] == 8'h00
    && cfg_rdata_o[22:16] == 7'h40) else $error("extension or data byte wrong");
  mirror_bits_a: assert property (rd54 |=>
    cfg_rdata_o[3] == $past(pm_revision_select_i)
    && cfg_rdata_o[23] == $past(secondary_clock_stop_setting_i)) else $error("mirror bit wrong");
  level_read_a: assert property (rd54 && !cfg_wr_i |=>
    cfg_rdata_o[1:0] == $past(device_power_level_o)) else $error("level readback wrong");
  level_write_a: assert property (wr54 && cfg_byte_en_i[0] |=>
    device_power_level_o == $past(cfg_wdata_i[1:0])) else $error("level not written");
  level_hold_a: assert property (!(wr54 && cfg_byte_en_i[0]) |=>
    $stable(device_power_level_o)) else $error("level changed without write");
  msi_id_a: assert property (cfg_rd_i && cfg_addr_i[7:2] == 6'h18 |=>
    cfg_rdata_o == 32'h00000005) else $error("capability id wrong");
  clock_stop_a: assert property ((device_power_level_o == 2'h3
    && secondary_clock_stop_setting_i) [*2] |-> secondary_clock_stop_o)
    else $error("clock not stopped");
  clock_run_a: assert property ((device_power_level_o != 2'h3) [*2] |->
    !secondary_clock_stop_o) else $error("clock stopped outside hot off");
  resume_pulse_a: assert property (device_power_level_o == 2'h0
    && $past(device_power_level_o) == 2'h3 |=> resumed_from_hot_off_o)
    else $error("no resume pulse");
  resume_once_a: assert property (resumed_from_hot_off_o |=>
    !resumed_from_hot_off_o) else $error("resume pulse too long");
endmodule // pm_regs_checker

bind pci_power_mgmt_regs pm_regs_checker chk (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
  .cfg_rd_i(cfg_rd_i), .cfg_wr_i(cfg_wr_i), .cfg_addr_i(cfg_addr_i),
  .cfg_byte_en_i(cfg_byte_en_i), .cfg_wdata_i(cfg_wdata_i), .cfg_rdata_o(cfg_rdata_o),
  .cfg_ack_o(cfg_ack_o), .cfg_hit_o(cfg_hit_o), .pm_revision_select_i(pm_revision_select_i),
  .secondary_clock_stop_setting_i(secondary_clock_stop_setting_i),
  .device_power_level_o(device_power_level_o), .secondary_clock_stop_o(secondary_clock_stop_o),
  .resumed_from_hot_off_o(resumed_from_hot_off_o), .entered_hot_off_o(entered_hot_off_o));

// >>> dv/test_pci_power_mgmt_regs.sv
`timescale 1ns/1ns
module test_pci_power_mgmt_regs;
  logic        sys_clk_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic        cfg_rd_i = 1'b0;
  logic        cfg_wr_i = 1'b0;
  logic [7:0]  cfg_addr_i = 8'h00;
  logic [3:0]  cfg_byte_en_i = 4'h0;
  logic [31:0] cfg_wdata_i = 32'h0;
  logic        rev_sel = 1'b1;
  logic        stop_set = 1'b0;
  logic [31:0] cfg_rdata_o;
  logic        cfg_ack_o;
  logic        cfg_hit_o;
  logic [1:0]  level_o;
  logic        stop_o;
  logic        resumed_o;
  logic        entered_o;
  logic [31:0] rd_q;
  int          error_cnt = 0;
  int          n_compared = 0;

  always #2 sys_clk_i = ~sys_clk_i;

  pci_power_mgmt_regs uut (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .cfg_rd_i(cfg_rd_i),
    .cfg_wr_i(cfg_wr_i), .cfg_addr_i(cfg_addr_i), .cfg_byte_en_i(cfg_byte_en_i),
    .cfg_wdata_i(cfg_wdata_i), .cfg_rdata_o(cfg_rdata_o), .cfg_ack_o(cfg_ack_o),
    .cfg_hit_o(cfg_hit_o), .pm_revision_select_i(rev_sel),
    .secondary_clock_stop_setting_i(stop_set), .device_power_level_o(level_o),
    .secondary_clock_stop_o(stop_o), .resumed_from_hot_off_o(resumed_o),
    .entered_hot_off_o(entered_o));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One config access, hit judged, read data kept in rd_q
  task automatic access(input logic wr, input logic [7:0] a, input logic [3:0] be,
                        input logic [31:0] d, input logic hit);
    int n;
    @(posedge sys_clk_i);
    cfg_rd_i <= !wr;
    cfg_wr_i <= wr;
    cfg_addr_i <= a;
    cfg_byte_en_i <= be;
    cfg_wdata_i <= d;
    @(posedge sys_clk_i);
    cfg_rd_i <= 1'b0;
    cfg_wr_i <= 1'b0;
    #1;
    for (n = 0; n < 4 && cfg_ack_o !== 1'b1; n++) @(posedge sys_clk_i) #1;
    if (n == 4) begin
      error_cnt++;
      $display("[ERR] %0t no acknowledge", $time);
      results();
    end
    cmp(cfg_hit_o, hit);
    rd_q = cfg_rdata_o;
  endtask

  function automatic logic [31:0] exp54(input logic [1:0] lvl, input logic scr);
    return {8'h00, stop_set, 7'h40, 7'h00, scr, 4'h0, rev_sel, 1'b0, lvl};
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_reset();
    access(1'b0, 8'h54, 4'h0, 32'h0, 1'b1);
    cmp(rd_q, exp54(2'h0, 1'b0));
    access(1'b0, 8'h60, 4'h0, 32'h0, 1'b1);
    cmp(rd_q, 32'h00000005);
    access(1'b0, 8'h58, 4'h0, 32'h0, 1'b0);
    cmp(rd_q, 32'h0);
    $display("test_reset done");
  endtask

  task automatic test_levels();
    for (int l = 0; l < 4; l++) begin
      @(posedge sys_clk_i);
      rev_sel <= l[0];
      access(1'b1, 8'h54, 4'hf, 32'hfffffffc | l, 1'b1);
      @(posedge sys_clk_i) #1;
      cmp(entered_o, l == 3);
      cmp(level_o, l);
      access(1'b0, 8'h54, 4'h0, 32'h0, 1'b1);
      cmp(rd_q, exp54(l, 1'b1));
    end
    $display("test_levels done");
  endtask

  task automatic test_resume();
    @(posedge sys_clk_i);
    stop_set <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    #1;
    cmp(stop_o, 1'b1);
    access(1'b1, 8'h54, 4'h2, 32'h0, 1'b1);
    access(1'b0, 8'h54, 4'h0, 32'h0, 1'b1);
    cmp(rd_q, exp54(2'h3, 1'b0));
    access(1'b1, 8'h54, 4'h3, 32'h00000100, 1'b1);
    @(posedge sys_clk_i) #1;
    cmp(resumed_o, 1'b1);
    @(posedge sys_clk_i) #1;
    cmp(stop_o, 1'b0);
    cmp(resumed_o, 1'b0);
    access(1'b0, 8'h54, 4'h0, 32'h0, 1'b1);
    cmp(rd_q, exp54(2'h0, 1'b1));
    $display("test_resume done");
  endtask

  task automatic test_readonly();
    access(1'b1, 8'h60, 4'hf, 32'hffffffff, 1'b1);
    access(1'b0, 8'h60, 4'h0, 32'h0, 1'b1);
    cmp(rd_q, 32'h00000005);
    access(1'b1, 8'h54, 4'hc, 32'hffffffff, 1'b1);
    access(1'b0, 8'h54, 4'h0, 32'h0, 1'b1);
    cmp(rd_q, exp54(2'h0, 1'b1));
    $display("test_readonly done");
  endtask

  initial begin
    repeat (10) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    test_reset();
    test_levels();
    test_resume();
    test_readonly();
    results();
  end
endmodule // test_pci_power_mgmt_regs
